// ### design/pdcc_pkg.sv
// package for the audio clock tree configuration block
package pdcc_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] PLL_PWR_PRE_ADDR      = 8'h05;
    localparam logic [7:0] PLL_INTEGER_MULT_ADDR = 8'h06;
    localparam logic [7:0] PLL_FRACTION_HI_ADDR  = 8'h07;
    localparam logic [7:0] PLL_FRACTION_LO_ADDR  = 8'h08;
    localparam logic [7:0] RESERVED_09_ADDR      = 8'h09;
    localparam logic [7:0] RESERVED_0A_ADDR      = 8'h0a;
    localparam logic [7:0] DAC_CLOCK_DIV_ADDR    = 8'h0b;
    localparam logic [7:0] DAC_MOD_DIV_ADDR      = 8'h0c;
    localparam logic [7:0] OVERSAMPLE_HI_ADDR    = 8'h0d;
    localparam logic [7:0] OVERSAMPLE_LO_ADDR    = 8'h0e;
    localparam logic [7:0] RESERVED_0F_ADDR      = 8'h0f;
    localparam logic [7:0] RESERVED_10_ADDR      = 8'h10;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int POWER_BIT    = 7;
    localparam int PRE_DIV_LSB  = 4;
    localparam int PLL_R_LSB    = 0;
    localparam int DIV_CODE_LSB = 0;

    // ****************************************************************
    // reset values and limits
    // ****************************************************************
    localparam logic [2:0]  PRE_DIV_RESET     = 3'h1;
    localparam logic [3:0]  PLL_R_RESET       = 4'h1;
    localparam logic [5:0]  INT_MULT_RESET    = 6'h04;
    localparam logic [5:0]  INT_MULT_MIN      = 6'h04;
    localparam logic [5:0]  FRACTION_HI_RESET = 6'h00;
    localparam logic [7:0]  FRACTION_LO_RESET = 8'h00;
    localparam logic [13:0] FRACTION_MAX      = 14'h270f;
    localparam logic [6:0]  DIV_CODE_RESET    = 7'h01;
    localparam logic [7:0]  DIV_FULL_COUNT    = 8'h80;
    localparam logic [1:0]  OSR_HI_RESET      = 2'h0;
    localparam logic [7:0]  OSR_LO_RESET      = 8'h80;
    localparam logic [10:0] OSR_FULL_RATIO    = 11'h400;
    localparam logic [3:0]  PRE_DIV_FULL      = 4'h8;
    localparam logic [7:0]  RESERVED_0F_VALUE = 8'h02;
    localparam logic [7:0]  RESERVED_VALUE    = 8'h00;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdcc_req_type;

    typedef struct packed {
        logic       pll_power;
        logic [3:0] pll_pre_divider;
        logic [5:0] pll_int_mult;
        logic [13:0] pll_fraction;
        logic [10:0] oversample_ratio;
    } pdcc_cfg_type;

    typedef struct packed {
        logic       pll_power;
        logic [2:0] pre_code;
        logic [3:0] r_code;
        logic [5:0] int_mult;
        logic [5:0] frac_hi;
        logic [7:0] frac_lo;
        logic       frac_pend;
        logic [5:0] frac_hi_pend;
        logic       dac_pwr;
        logic [6:0] dac_code;
        logic       mod_pwr;
        logic [6:0] mod_code;
        logic [1:0] osr_hi;
        logic [7:0] osr_lo;
        logic       osr_pend;
        logic [1:0] osr_hi_pend;
        logic [7:0] rd_data;
    } pdcc_regs_type;

    typedef struct packed {
        logic [6:0] count;
        logic       tick;
    } pdcc_div_type;

endpackage

// ### design/pdcc_divider.sv
// powered clock divider producing one-cycle enable pulses
module pdcc_divider
    import pdcc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       tick_in,
    input  wire logic       power,
    input  wire logic [6:0] code,
    output logic            tick_out
);

    pdcc_div_type s_q;
    pdcc_div_type s_d;
    logic [7:0]   divisor;

    // code zero selects the full count of 128
    assign divisor = (code == 7'h00) ? DIV_FULL_COUNT : {1'b0, code};

    // count input ticks; powered down holds the counter cleared so a
    // power-up always starts a whole period
    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!power)
        begin
            s_d.count = 7'h00;
        end
        else if (tick_in)
        begin
            if ({1'b0, s_q.count} >= divisor - 8'h01)
            begin
                s_d.count = 7'h00;
                s_d.tick  = 1'b1;
            end
            else
            begin
                s_d.count = s_q.count + 7'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.tick;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_div_off_silent: assert property (!power |=> !tick_out)
        else $error("divider ticked while powered down");
    a_div_full_count: assert property (power && tick_in && code == 7'h00 && s_q.count == 7'h7e
        |=> s_q.count == 7'h7f && !tick_out)
        else $error("code zero did not count to 128");
    a_div_unit_pass: assert property (power && tick_in && code == 7'h01 |=> tick_out)
        else $error("divide by one did not pass each tick");

endmodule

// ### design/pdcc_top.sv
// audio clock tree configuration registers and cascaded dac dividers
module pdcc_top
    import pdcc_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   arst_n,
    input  pdcc_req_type reg_req,
    output logic [7:0]  reg_rd_data,
    output pdcc_cfg_type cfg,
    output logic        dac_clk_en,
    output logic        dac_mod_clk_en
);

    pdcc_regs_type r_q;
    pdcc_regs_type r_d;
    logic [13:0]   frac_candidate;
    logic [13:0]   frac_applied;
    logic          wr_int;
    logic          wr_frac_hi;
    logic          wr_frac_lo;
    logic          wr_osr_hi;
    logic          wr_osr_lo;

    // ****************************************************************
    // write decode
    // ****************************************************************

    // strobes for the multiplier and the split halves only; reserved offsets take no state but still
    // count as a write for breaking a pending pair
    assign wr_int     = reg_req.wr_en && (reg_req.addr == PLL_INTEGER_MULT_ADDR);
    assign wr_frac_hi = reg_req.wr_en && (reg_req.addr == PLL_FRACTION_HI_ADDR);
    assign wr_frac_lo = reg_req.wr_en && (reg_req.addr == PLL_FRACTION_LO_ADDR);
    assign wr_osr_hi  = reg_req.wr_en && (reg_req.addr == OVERSAMPLE_HI_ADDR);
    assign wr_osr_lo  = reg_req.wr_en && (reg_req.addr == OVERSAMPLE_LO_ADDR);

    // the low write joins the pending high part, or the applied one if none waits
    assign frac_candidate = r_q.frac_pend ? {r_q.frac_hi_pend, reg_req.wdata}
                                          : {r_q.frac_hi, reg_req.wdata};
    assign frac_applied   = {r_q.frac_hi, r_q.frac_lo};

    // ****************************************************************
    // register state
    // ****************************************************************

    // all register writes, pairing of split values and the read port
    always_comb
    begin
        r_d = r_q;
        if (reg_req.wr_en)
        begin
            // any write ends a pending pair, the matching low part included; only a new high part of that pair sets it again
            r_d.frac_pend = 1'b0;
            r_d.osr_pend  = 1'b0;
            case (reg_req.addr)
                PLL_PWR_PRE_ADDR:
                begin
                    r_d.pll_power = reg_req.wdata[POWER_BIT];
                    r_d.pre_code  = reg_req.wdata[PRE_DIV_LSB +: 3];
                    r_d.r_code    = reg_req.wdata[PLL_R_LSB +: 4];
                end
                PLL_INTEGER_MULT_ADDR:
                begin
                    // codes below four are unusable, so they are dropped
                    if (reg_req.wdata[5:0] >= INT_MULT_MIN)
                    begin
                        r_d.int_mult = reg_req.wdata[5:0];
                    end
                end
                PLL_FRACTION_HI_ADDR:
                begin
                    r_d.frac_pend    = 1'b1;
                    r_d.frac_hi_pend = reg_req.wdata[5:0];
                end
                PLL_FRACTION_LO_ADDR:
                begin
                    // an out-of-range pair never reaches the pll
                    if (frac_candidate <= FRACTION_MAX)
                    begin
                        r_d.frac_hi = frac_candidate[13:8];
                        r_d.frac_lo = frac_candidate[7:0];
                    end
                end
                DAC_CLOCK_DIV_ADDR:
                begin
                    r_d.dac_pwr  = reg_req.wdata[POWER_BIT];
                    r_d.dac_code = reg_req.wdata[DIV_CODE_LSB +: 7];
                end
                DAC_MOD_DIV_ADDR:
                begin
                    r_d.mod_pwr  = reg_req.wdata[POWER_BIT];
                    r_d.mod_code = reg_req.wdata[DIV_CODE_LSB +: 7];
                end
                OVERSAMPLE_HI_ADDR:
                begin
                    r_d.osr_pend    = 1'b1;
                    r_d.osr_hi_pend = reg_req.wdata[1:0];
                end
                OVERSAMPLE_LO_ADDR:
                begin
                    if (r_q.osr_pend)
                    begin
                        r_d.osr_hi = r_q.osr_hi_pend;
                    end
                    r_d.osr_lo = reg_req.wdata;
                end
                default:
                begin
                    // reserved and unknown offsets hold no state
                    r_d.rd_data = r_q.rd_data;
                end
            endcase
        end
        // read data is registered; split values read back as applied
        if (reg_req.rd_en)
        begin
            case (reg_req.addr)
                PLL_PWR_PRE_ADDR:      r_d.rd_data = {r_q.pll_power, r_q.pre_code, r_q.r_code};
                PLL_INTEGER_MULT_ADDR: r_d.rd_data = {2'h0, r_q.int_mult};
                PLL_FRACTION_HI_ADDR:  r_d.rd_data = {2'h0, r_q.frac_hi};
                PLL_FRACTION_LO_ADDR:  r_d.rd_data = r_q.frac_lo;
                DAC_CLOCK_DIV_ADDR:    r_d.rd_data = {r_q.dac_pwr, r_q.dac_code};
                DAC_MOD_DIV_ADDR:      r_d.rd_data = {r_q.mod_pwr, r_q.mod_code};
                OVERSAMPLE_HI_ADDR:    r_d.rd_data = {6'h00, r_q.osr_hi};
                OVERSAMPLE_LO_ADDR:    r_d.rd_data = r_q.osr_lo;
                RESERVED_0F_ADDR:      r_d.rd_data = RESERVED_0F_VALUE;
                default:               r_d.rd_data = RESERVED_VALUE;
            endcase
        end
    end

    // register the whole state; reset restores every documented default
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r_q              <= '0;
            r_q.pre_code     <= PRE_DIV_RESET;
            r_q.r_code       <= PLL_R_RESET;
            r_q.int_mult     <= INT_MULT_RESET;
            r_q.frac_hi      <= FRACTION_HI_RESET;
            r_q.frac_lo      <= FRACTION_LO_RESET;
            r_q.dac_code     <= DIV_CODE_RESET;
            r_q.mod_code     <= DIV_CODE_RESET;
            r_q.osr_hi       <= OSR_HI_RESET;
            r_q.osr_lo       <= OSR_LO_RESET;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // decoded configuration
    // ****************************************************************

    // zero codes stand for the top of the pre-divider and oversample ranges
    always_comb
    begin
        cfg.pll_power        = r_q.pll_power;
        cfg.pll_pre_divider  = (r_q.pre_code == 3'h0) ? PRE_DIV_FULL : {1'b0, r_q.pre_code};
        cfg.pll_int_mult     = r_q.int_mult;
        cfg.pll_fraction     = frac_applied;
        cfg.oversample_ratio = ({r_q.osr_hi, r_q.osr_lo} == 10'h000) ? OSR_FULL_RATIO
                                                                    : {1'b0, r_q.osr_hi, r_q.osr_lo};
    end

    assign reg_rd_data = r_q.rd_data;

    // ****************************************************************
    // cascaded dac dividers
    // ****************************************************************

    // the first divider sees every codec clock, the second its output;
    // powering the first down also starves the second
    pdcc_divider u_dac_div
    (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tick_in  (1'b1),
        .power    (r_q.dac_pwr),
        .code     (r_q.dac_code),
        .tick_out (dac_clk_en)
    );

    pdcc_divider u_mod_div
    (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tick_in  (dac_clk_en),
        .power    (r_q.mod_pwr),
        .code     (r_q.mod_code),
        .tick_out (dac_mod_clk_en)
    );

    // ****************************************************************
    // checks
    // ****************************************************************

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_int_mult_reject: assert property (wr_int && reg_req.wdata[5:0] < 6'h04
        |=> $stable(cfg.pll_int_mult))
        else $error("unusable multiplier code was taken");
    a_int_mult_take: assert property (wr_int && reg_req.wdata[5:0] >= 6'h04
        |=> cfg.pll_int_mult == $past(reg_req.wdata[5:0]))
        else $error("legal multiplier code not taken");
    a_frac_hold_high: assert property (wr_frac_hi |=> $stable(cfg.pll_fraction) && r_q.frac_pend)
        else $error("fraction changed on high write");
    a_frac_pair_apply: assert property (wr_frac_lo && r_q.frac_pend && frac_candidate <= 14'h270f
        |=> cfg.pll_fraction == $past(frac_candidate) && !r_q.frac_pend)
        else $error("fraction pair not applied");
    a_frac_range_guard: assert property (cfg.pll_fraction <= 14'h270f)
        else $error("fraction beyond 9999");
    a_frac_discard: assert property (r_q.frac_pend && reg_req.wr_en && !wr_frac_lo && !wr_frac_hi
        |=> !r_q.frac_pend && $stable(cfg.pll_fraction))
        else $error("pending fraction high part survived");
    a_osr_pair_apply: assert property (wr_osr_lo && r_q.osr_pend
        |=> {r_q.osr_hi, r_q.osr_lo} == {$past(r_q.osr_hi_pend), $past(reg_req.wdata)})
        else $error("oversample pair not applied");
    a_osr_hold_high: assert property (wr_osr_hi |=> $stable(cfg.oversample_ratio))
        else $error("oversample changed on high write");
    a_osr_zero_full: assert property ({r_q.osr_hi, r_q.osr_lo} == 10'h000
        |-> cfg.oversample_ratio == 11'h400)
        else $error("code zero is not 1024");
    a_mod_needs_dac: assert property (!r_q.dac_pwr [*2] |=> !dac_mod_clk_en)
        else $error("modulator clock ran without dac clock");

    // ****************************************************************
    // checks on the pll register and the multiplier
    // ****************************************************************

    // power and pre-divider follow the write to their shared register
    a_pll_power_take: assert property (reg_req.wr_en && reg_req.addr == PLL_PWR_PRE_ADDR
        |=> cfg.pll_power == $past(reg_req.wdata[POWER_BIT]))
        else $error("pll power bit not taken");
    a_pre_div_take: assert property (reg_req.wr_en && reg_req.addr == PLL_PWR_PRE_ADDR
        |=> r_q.pre_code == $past(reg_req.wdata[PRE_DIV_LSB +: 3]))
        else $error("pre-divider code not taken");
    a_pre_div_zero: assert property (r_q.pre_code == 3'h0
        |-> cfg.pll_pre_divider == PRE_DIV_FULL)
        else $error("pre-divider code zero is not 8");
    a_pre_div_range: assert property (cfg.pll_pre_divider != 4'h0
        && cfg.pll_pre_divider <= PRE_DIV_FULL)
        else $error("pre-divider outside 1 to 8");
    a_int_mult_floor: assert property (cfg.pll_int_mult >= INT_MULT_MIN)
        else $error("multiplier below four");

    // ****************************************************************
    // checks on the split values
    // ****************************************************************

    // a refused or lone low part must never disturb the applied high part
    a_frac_refuse: assert property (wr_frac_lo && frac_candidate > FRACTION_MAX
        |=> $stable(cfg.pll_fraction) && !r_q.frac_pend)
        else $error("fraction beyond 9999 was applied");
    a_frac_lone_low: assert property (wr_frac_lo && !r_q.frac_pend
        |=> cfg.pll_fraction[13:8] == $past(cfg.pll_fraction[13:8]))
        else $error("lone fraction low part moved the high part");
    a_frac_low_ends: assert property (wr_frac_lo |=> !r_q.frac_pend)
        else $error("fraction pair still pending");
    a_frac_read_applied: assert property (reg_req.rd_en && reg_req.addr == PLL_FRACTION_HI_ADDR
        |=> reg_rd_data == {2'h0, $past(cfg.pll_fraction[13:8])})
        else $error("fraction read showed a pending part");
    a_osr_discard: assert property (r_q.osr_pend && reg_req.wr_en && !wr_osr_lo && !wr_osr_hi
        |=> !r_q.osr_pend && $stable(cfg.oversample_ratio))
        else $error("pending oversample high part survived");
    a_osr_lone_low: assert property (wr_osr_lo && !r_q.osr_pend
        |=> r_q.osr_hi == $past(r_q.osr_hi))
        else $error("lone oversample low part moved the high part");
    a_osr_low_take: assert property (wr_osr_lo
        |=> r_q.osr_lo == $past(reg_req.wdata))
        else $error("oversample low part not taken");
    a_osr_read_applied: assert property (reg_req.rd_en && reg_req.addr == OVERSAMPLE_HI_ADDR
        |=> reg_rd_data == {6'h00, $past(r_q.osr_hi)})
        else $error("oversample read showed a pending part");
    a_osr_range: assert property (cfg.oversample_ratio != 11'h000
        && cfg.oversample_ratio <= OSR_FULL_RATIO)
        else $error("oversample ratio outside 1 to 1024");

    // ****************************************************************
    // checks on the dac dividers
    // ****************************************************************

    // power and code land together; an unpowered divider stays silent and
    // the second divider can only tick right after a tick of the first
    a_dac_div_take: assert property (reg_req.wr_en && reg_req.addr == DAC_CLOCK_DIV_ADDR
        |=> r_q.dac_pwr == $past(reg_req.wdata[POWER_BIT]) && r_q.dac_code == $past(reg_req.wdata[6:0]))
        else $error("dac divider register not taken");
    a_mod_div_take: assert property (reg_req.wr_en && reg_req.addr == DAC_MOD_DIV_ADDR
        |=> r_q.mod_pwr == $past(reg_req.wdata[POWER_BIT]) && r_q.mod_code == $past(reg_req.wdata[6:0]))
        else $error("modulator divider register not taken");
    a_dac_off_quiet: assert property (!r_q.dac_pwr
        |=> !dac_clk_en)
        else $error("dac clock ran while powered down");
    a_mod_off_quiet: assert property (!r_q.mod_pwr
        |=> !dac_mod_clk_en)
        else $error("modulator clock ran while powered down");
    a_mod_follows_dac: assert property (dac_mod_clk_en
        |-> $past(dac_clk_en))
        else $error("modulator ticked without a dac tick");

endmodule

// ### tb/pdcc_host_model.sv
// host-side model that drives the register port of the clock configuration block
module pdcc_host_model
    import pdcc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rd_data,
    output pdcc_req_type    reg_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // bus idle state
    // ****************************************************************
    // idle at time zero so the first edge after reset sees no request
    initial
    begin
        reg_req = '0;
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    // one write: launched after an edge, held through the taking edge, then released
    // released address and data are inverted so stale values are never mistaken for live ones
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wdata: data};
        @(posedge core_clk);
        reg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // one read: data is registered, so it is taken half a cycle after the taking edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        reg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wdata: ~addr};
        @(posedge core_clk);
        reg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~addr, wdata: addr};
        @(negedge core_clk);
        data = reg_rd_data;
    endtask

    // split value: high part, then its low part as the very next write
    // callers hand only legal values here; refusal tests use wr directly
    task automatic wr_split(input logic [7:0] hi_addr, input logic [13:0] value);
        wr(hi_addr, {2'h0, value[13:8]});
        wr(hi_addr + 8'h01, value[7:0]);
    endtask
endmodule

// ### tb/tb_top.sv
// self-checking testbench for the clock configuration block
`define CHK(name, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); \
        end \
    end

module tb_top
    import pdcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         core_clk;
    logic         arst_n;
    pdcc_req_type reg_req;
    logic [7:0]   reg_rd_data;
    pdcc_cfg_type cfg;
    logic         dac_clk_en;
    logic         dac_mod_clk_en;
    int           error_cnt;
    int           num_checks;
    int           cycles;
    logic [7:0]   rst_val [11] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                                   8'h01, 8'h00, 8'h80, 8'h02, 8'h00};

    // ****************************************************************
    // design and host
    // ****************************************************************
    pdcc_top DUT (
        .core_clk       (core_clk),
        .arst_n         (arst_n),
        .reg_req        (reg_req),
        .reg_rd_data    (reg_rd_data),
        .cfg            (cfg),
        .dac_clk_en     (dac_clk_en),
        .dac_mod_clk_en (dac_mod_clk_en)
    );

    pdcc_host_model host (
        .core_clk    (core_clk),
        .reg_rd_data (reg_rd_data),
        .reg_req     (reg_req)
    );

    // ****************************************************************
    // clock, reset and hang guard
    // ****************************************************************
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // the run needs about 1700 cycles; the ceiling leaves ample margin
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(addr, d);
        `CHK("read data", exp, d)
    endtask

    // a settle period lets dividers pass any start-up wrap, then a window of whole periods is counted
    task automatic count(input int n, input int exp_d, input int exp_m);
        int d;
        int m;
        d = 0;
        m = 0;
        repeat (300) @(negedge core_clk);
        repeat (n)
        begin
            @(negedge core_clk);
            if (dac_clk_en === 1'b1)
                d++;
            if (dac_mod_clk_en === 1'b1)
                m++;
        end
        `CHK("dac clock pulses", exp_d, d)
        `CHK("modulator pulses", exp_m, m)
    endtask

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        error_cnt = 0;
        num_checks = 0;
        cycles = 0;
        arst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        // reset values of every register except the pll power and pre-divider one
        for (int i = 0; i < 11; i++)
            rd_chk(8'h06 + 8'(i), rst_val[i]);
        `CHK("int mult", 6'h04, cfg.pll_int_mult)
        `CHK("oversample", 11'h080, cfg.oversample_ratio)
        `CHK("pre divider", 4'h1, cfg.pll_pre_divider)
        `CHK("pll power", 1'b0, cfg.pll_power)
        `CHK("fraction", 14'h0000, cfg.pll_fraction)
        // multiplier: code below the minimum is ignored, the top code is taken
        host.wr(PLL_INTEGER_MULT_ADDR, 8'h03);
        @(negedge core_clk);
        `CHK("int mult", 6'h04, cfg.pll_int_mult)
        host.wr(PLL_INTEGER_MULT_ADDR, 8'h3f);
        @(negedge core_clk);
        `CHK("int mult", 6'h3f, cfg.pll_int_mult)
        // pll power up with pre-divider code 0
        host.wr(PLL_PWR_PRE_ADDR, 8'h81);
        @(negedge core_clk);
        `CHK("pll power", 1'b1, cfg.pll_power)
        `CHK("pre divider", 4'h8, cfg.pll_pre_divider)
        rd_chk(PLL_PWR_PRE_ADDR, 8'h81);
        // fraction: high part stays pending across a read, applied by the low write
        host.wr(PLL_FRACTION_HI_ADDR, 8'h27);
        rd_chk(PLL_FRACTION_HI_ADDR, 8'h00);
        `CHK("fraction", 14'h0000, cfg.pll_fraction)
        host.wr(PLL_FRACTION_LO_ADDR, 8'h0f);
        @(negedge core_clk);
        `CHK("fraction", 14'h270f, cfg.pll_fraction)
        // one above the top legal value is refused
        host.wr(PLL_FRACTION_HI_ADDR, 8'h27);
        host.wr(PLL_FRACTION_LO_ADDR, 8'h10);
        @(negedge core_clk);
        `CHK("fraction", 14'h270f, cfg.pll_fraction)
        // another write between the halves discards the pending high part
        host.wr(PLL_FRACTION_HI_ADDR, 8'h01);
        host.wr(DAC_CLOCK_DIV_ADDR, 8'h01);
        host.wr(PLL_FRACTION_LO_ADDR, 8'h00);
        @(negedge core_clk);
        `CHK("fraction", 14'h2700, cfg.pll_fraction)
        rd_chk(PLL_FRACTION_HI_ADDR, 8'h27);
        // oversample ratio: top code and code 0
        host.wr_split(OVERSAMPLE_HI_ADDR, 14'h03ff);
        @(negedge core_clk);
        `CHK("oversample", 11'h3ff, cfg.oversample_ratio)
        host.wr_split(OVERSAMPLE_HI_ADDR, 14'h0000);
        @(negedge core_clk);
        `CHK("oversample", 11'h400, cfg.oversample_ratio)
        host.wr(OVERSAMPLE_HI_ADDR, 8'h01);
        host.wr(PLL_INTEGER_MULT_ADDR, 8'h3f);
        host.wr(OVERSAMPLE_LO_ADDR, 8'h05);
        @(negedge core_clk);
        `CHK("oversample", 11'h005, cfg.oversample_ratio)
        host.wr(OVERSAMPLE_HI_ADDR, 8'h02);
        @(negedge core_clk);
        `CHK("oversample", 11'h005, cfg.oversample_ratio)
        host.wr(OVERSAMPLE_LO_ADDR, 8'h00);
        @(negedge core_clk);
        `CHK("oversample", 11'h200, cfg.oversample_ratio)
        // reserved and unmapped places store nothing
        host.wr(8'h20, 8'h55);
        host.wr(RESERVED_09_ADDR, 8'h00);
        rd_chk(RESERVED_09_ADDR, 8'h00);
        rd_chk(PLL_INTEGER_MULT_ADDR, 8'h3f);
        // dividers: 2 and 3 give 30 and 10 pulses in 60 cycles
        host.wr(DAC_CLOCK_DIV_ADDR, 8'h82);
        host.wr(DAC_MOD_DIV_ADDR, 8'h83);
        count(60, 30, 10);
        host.wr(DAC_CLOCK_DIV_ADDR, 8'h81);
        host.wr(DAC_MOD_DIV_ADDR, 8'h80);
        count(256, 256, 2);
        host.wr(DAC_MOD_DIV_ADDR, 8'h03);
        count(60, 60, 0);
        host.wr(DAC_CLOCK_DIV_ADDR, 8'h00);
        count(60, 0, 0);
        end_of_test();
    end
endmodule
